// ### fgc_assertions.sv
// Purpose: port checks for fgc_top
// Assumes: one clock, async high reset
// Notes:   start spacing check assumes SMP_DIV of 10
module fgc_checker
  import fgc_pkg::*;
#(parameter int unsigned WIN_CYCLES = 200, SMP_DIV = 10) (
  // clock, reset, inputs
  input wire logic             clk_sys, rst, sat_detect, adc_valid,
  input wire logic [ADC_W-1:0] adc_code, dc_trip_th, ac_trip_th, hyst_th,
  // outputs
  input wire logic             bridge_in1, bridge_in2, adc_start, relay_trip, monitoring,
  input wire logic [1:0]       fault_type
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // the lower threshold arms a window
  wire logic [ADC_W-1:0] low_th = (dc_trip_th < ac_trip_th) ? dc_trip_th : ac_trip_th;
  wire logic             idle   = !monitoring && !relay_trip;
  wire logic             rel    = adc_valid && adc_code < hyst_th;
  // window too long for a repetition, so count it
  logic [31:0] win_cnt_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) win_cnt_r <= '0;
    else win_cnt_r <= monitoring ? win_cnt_r + 1 : '0;
  end
  property p_cmp; bridge_in1 != bridge_in2; endproperty
  a_cmp: assert property (p_cmp) else $error("bridge not complementary");
  property p_tog; $rose(sat_detect) |=> bridge_in1 != $past(bridge_in1); endproperty
  a_tog: assert property (p_tog) else $error("no flip on saturation");
  property p_hold; !$rose(sat_detect) |=> $stable(bridge_in1); endproperty
  a_hold: assert property (p_hold) else $error("flip without saturation");
  // a start every tenth cycle leaves nine quiet cycles between pulses
  property p_smp; adc_start |=> !adc_start [*8] ##1 !adc_start ##1 adc_start; endproperty
  a_smp: assert property (p_smp) else $error("start spacing wrong");
  property p_arm; idle && adc_valid && adc_code > low_th |=> monitoring; endproperty
  a_arm: assert property (p_arm) else $error("window not armed");
  property p_ign; idle && adc_valid && adc_code <= low_th |=> !monitoring; endproperty
  a_ign: assert property (p_ign) else $error("armed below threshold");
  property p_win; $fell(monitoring) |-> win_cnt_r >= WIN_CYCLES - 1 && win_cnt_r <= WIN_CYCLES + 1; endproperty
  a_win: assert property (p_win) else $error("window length wrong");
  property p_trip; $rose(relay_trip) |-> $fell(monitoring) && fault_type != FGC_NONE; endproperty
  a_trip: assert property (p_trip) else $error("trip outside decision");
  property p_rel; relay_trip |=> relay_trip == !$past(rel); endproperty
  a_rel: assert property (p_rel) else $error("trip release wrong");
endmodule : fgc_checker
bind fgc_top fgc_checker #(.WIN_CYCLES(WIN_CYCLES), .SMP_DIV(SMP_DIV)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .sat_detect(sat_detect), .adc_valid(adc_valid), .adc_code(adc_code), .dc_trip_th(dc_trip_th),
  .ac_trip_th(ac_trip_th), .hyst_th(hyst_th), .bridge_in1(bridge_in1), .bridge_in2(bridge_in2),
  .adc_start(adc_start), .relay_trip(relay_trip), .monitoring(monitoring), .fault_type(fault_type));

// ### fgc_ext_if.sv
// Purpose: extremes carrier between classifier and tracker
// Assumes: one clock domain
// Notes:   clear has priority over a sample in the tracker
interface fgc_ext_if;
  logic       clear;
  logic       sample_vld;
  logic [9:0] sample;
  logic [9:0] hi;
  logic [9:0] lo;
  modport ctrl (output clear, output sample_vld, output sample, input hi, input lo);
  modport trk  (input clear, input sample_vld, input sample, output hi, output lo);
endinterface : fgc_ext_if

// ### fgc_extreme_track.sv
// Purpose: keeps highest and lowest sample of a window
// Assumes: clear and sample come from the classifier
// Notes:   after clear, hi reads zero and lo reads all ones
module fgc_extreme_track
  import fgc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // carrier
  fgc_ext_if.trk   ext
);
  // ----------------------------------------------------------------
  // extremes
  // ----------------------------------------------------------------
  // clear first so a new window never inherits old extremes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext.hi <= 10'h000;
      ext.lo <= 10'h3FF;
    end else if (ext.clear) begin
      ext.hi <= 10'h000;
      ext.lo <= 10'h3FF;
    end else if (ext.sample_vld) begin
      if (ext.sample > ext.hi) ext.hi <= ext.sample;
      if (ext.sample < ext.lo) ext.lo <= ext.sample;
    end
  end
endmodule : fgc_extreme_track

// ### fgc_partner.sv
// Purpose: comparator and converter model facing fgc_top
// Assumes: bench sets level, ac_mode and skew
// Notes:   skew lengthens one direction like a steady fault
module fgc_partner
  import fgc_pkg::*;
(
  // clock and reset
  input wire logic             clk_sys, rst,
  // bridge and converter
  input wire logic             bridge_in1, adc_start, ac_mode,
  input wire logic [ADC_W-1:0] level,
  input wire logic [7:0]       skew,
  output logic                 sat_detect, adc_valid,
  output logic [ADC_W-1:0]     adc_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  logic       dir_r;
  logic [2:0] smp_r;
  // coil current ramps until the comparator trips, clears on reversal
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r      <= '0;
      dir_r      <= 1'b0;
      sat_detect <= 1'b0;
    end else begin
      dir_r      <= bridge_in1;
      cnt_r      <= (bridge_in1 != dir_r) ? 8'h00 : cnt_r + 8'h01;
      sat_detect <= (bridge_in1 == dir_r) && cnt_r >= 8'h14 + (bridge_in1 ? skew : 8'h00);
    end
  end
  // one code per start; stale code is not held, ac dips to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adc_valid <= 1'b0;
      adc_code  <= '0;
      smp_r     <= '0;
    end else begin
      adc_valid <= adc_start;
      adc_code  <= !adc_start ? ~adc_code : (ac_mode && smp_r[2]) ? '0 : level;
      smp_r     <= smp_r + 3'(adc_start);
    end
  end
endmodule : fgc_partner

// ### fgc_pkg.sv
// Purpose: shared constants for the fluxgate drive and fault classifier
// Assumes: 100 MHz system clock, 10-bit converter codes over 1.5 V
// Notes:   thresholds are codes, code = mV * 1023 / 1500
package fgc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned SAMPLE_RATE_SPS  = 4000;        // above 2000
  localparam int unsigned SAMPLE_DIV       = CLK_HZ / SAMPLE_RATE_SPS;
  localparam int unsigned WINDOW_MS        = 13;
  localparam int unsigned WINDOW_CYC       = (CLK_HZ / 1000) * WINDOW_MS;
  // ----------------------------------------------------------------
  // converter code space
  // ----------------------------------------------------------------
  localparam int unsigned ADC_W            = 10;
  localparam int unsigned FULL_SCALE_MV    = 1500;
  localparam int unsigned DC_TRIP_MV       = 200;
  localparam int unsigned AC_TRIP_MV       = 600;
  localparam int unsigned NEAR_ZERO_MV     = 30;
  localparam int unsigned HYST_MV          = 100;
  localparam logic [9:0]  DC_TRIP_CODE  = 10'((DC_TRIP_MV * 1023) / FULL_SCALE_MV);
  localparam logic [9:0]  AC_TRIP_CODE  = 10'((AC_TRIP_MV * 1023) / FULL_SCALE_MV);
  localparam logic [9:0]  NEAR_ZERO_CODE = 10'((NEAR_ZERO_MV * 1023) / FULL_SCALE_MV);
  localparam logic [9:0]  HYST_CODE     = 10'((HYST_MV * 1023) / FULL_SCALE_MV);
  // ----------------------------------------------------------------
  // reset values and types
  // ----------------------------------------------------------------
  localparam logic        DIR_RST          = 1'b0;
  typedef enum logic [1:0] {
    FGC_NONE = 2'b00,
    FGC_DC   = 2'b01,
    FGC_AC   = 2'b10
  } fgc_fault_t;
  typedef enum logic [1:0] {
    FGC_IDLE    = 2'b00,
    FGC_MONITOR = 2'b01,
    FGC_TRIPPED = 2'b11
  } fgc_state_t;
endpackage : fgc_pkg

// ### fgc_top.sv
// Purpose: drive direction toggle and AC/DC residual fault classifier
// Assumes: comparator and converter outputs are synchronous to clk_sys
// Notes:   converter start pulse paces sampling; result valid strobes a code

module fgc_top
  import fgc_pkg::*;
#(
  parameter int unsigned WIN_CYCLES = WINDOW_CYC,
  parameter int unsigned SMP_DIV    = SAMPLE_DIV
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // saturation comparator and bridge
  input  wire logic             sat_detect,
  output logic                  bridge_in1,
  output logic                  bridge_in2,
  // converter
  output logic                  adc_start,
  input  wire logic             adc_valid,
  input  wire logic [ADC_W-1:0] adc_code,
  // thresholds
  input  wire logic [ADC_W-1:0] dc_trip_th,
  input  wire logic [ADC_W-1:0] ac_trip_th,
  input  wire logic [ADC_W-1:0] hyst_th,
  // result
  output logic                  relay_trip,
  output logic [1:0]            fault_type,
  output logic                  monitoring
);
  // ----------------------------------------------------------------
  // direction toggle flop
  // ----------------------------------------------------------------
  logic sat_prev_r;
  logic direction_toggle_flop_r;

  // edge detect on the comparator level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sat_prev_r <= 1'b0;
    else     sat_prev_r <= sat_detect;
  end

  // inverted state fed back; equal time per direction keeps duty at half
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      direction_toggle_flop_r <= DIR_RST;
    end else if (sat_detect && !sat_prev_r) begin
      direction_toggle_flop_r <= ~direction_toggle_flop_r;
    end
  end

  // both outputs registered from the same edge so they never overlap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bridge_in1 <= DIR_RST;
      bridge_in2 <= ~DIR_RST;
    end else if (sat_detect && !sat_prev_r) begin
      bridge_in1 <= ~direction_toggle_flop_r;
      bridge_in2 <= direction_toggle_flop_r;
    end
  end

  // ----------------------------------------------------------------
  // sample pacing
  // ----------------------------------------------------------------
  logic [31:0] smp_cnt_r;

  // one-cycle start pulse at SMP_DIV cycle intervals
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smp_cnt_r <= 32'h0000_0000;
      adc_start <= 1'b0;
    end else if (smp_cnt_r >= 32'(SMP_DIV - 1)) begin
      smp_cnt_r <= 32'h0000_0000;
      adc_start <= 1'b1;
    end else begin
      smp_cnt_r <= smp_cnt_r + 32'h0000_0001;
      adc_start <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // classifier
  // ----------------------------------------------------------------
  fgc_ext_if  ext ();
  fgc_state_t state_r;
  logic [31:0] win_cnt_r;
  logic [ADC_W-1:0] lower_th;

  function automatic logic [ADC_W-1:0] min_code(input logic [ADC_W-1:0] a, input logic [ADC_W-1:0] b);
    min_code = (a < b) ? a : b;
  endfunction : min_code

  // arming uses whichever threshold is lower
  assign lower_th       = min_code(dc_trip_th, ac_trip_th);
  assign ext.sample     = adc_code;
  assign ext.sample_vld = adc_valid && (state_r == FGC_MONITOR);
  assign ext.clear      = (state_r == FGC_IDLE) && !(adc_valid && adc_code > lower_th);

  fgc_extreme_track u_track (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ext     (ext)
  );

  // window, decision and trip release; a fault not found drops to idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= FGC_IDLE;
      win_cnt_r  <= 32'h0000_0000;
      relay_trip <= 1'b0;
      fault_type <= FGC_NONE;
      monitoring <= 1'b0;
    end else begin
      case (state_r)
        FGC_IDLE: begin
          relay_trip <= 1'b0;
          if (adc_valid && adc_code > lower_th) begin
            state_r    <= FGC_MONITOR;
            win_cnt_r  <= 32'h0000_0000;
            monitoring <= 1'b1;
          end
        end
        FGC_MONITOR: begin
          if (win_cnt_r >= 32'(WIN_CYCLES - 1)) begin
            monitoring <= 1'b0;
            // dc threshold input defaults to the 200 mV code, ac to the 600 mV code
            if (ext.lo > dc_trip_th) begin
              state_r    <= FGC_TRIPPED;
              fault_type <= FGC_DC;
              relay_trip <= 1'b1;
            end else if (ext.lo <= NEAR_ZERO_CODE && ext.hi > ac_trip_th) begin
              state_r    <= FGC_TRIPPED;
              fault_type <= FGC_AC;
              relay_trip <= 1'b1;
            end else begin
              state_r <= FGC_IDLE;
            end
          end else begin
            win_cnt_r <= win_cnt_r + 32'h0000_0001;
          end
        end
        FGC_TRIPPED: begin
          // release only on a fresh sample under hysteresis
          if (adc_valid && adc_code < hyst_th) begin
            state_r    <= FGC_IDLE;
            relay_trip <= 1'b0;
          end
        end
        default: begin
          state_r <= FGC_IDLE;
        end
      endcase
    end
  end
endmodule : fgc_top

// ### fgc_top_bench.sv
// Purpose: self-checking bench for fgc_top
// Assumes: short window and sample divider
// Notes:   reset and duty first, then corners, random levels and a raised dc threshold
module fgc_top_bench
  import fgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WIN = 200;
  logic clk_sys, rst, sat_detect, bridge_in1, bridge_in2, adc_start, adc_valid, ac_mode, relay_trip, monitoring;
  logic [ADC_W-1:0] adc_code, level, dc_th, ac_th, hyst_th;
  logic [7:0]       skew;
  logic [1:0]       fault_type;
  int               num_errors = 0, num_checks = 0, cyc = 0, hi, lo;
  fgc_top #(.WIN_CYCLES(WIN), .SMP_DIV(10)) dut (.clk_sys(clk_sys), .rst(rst), .sat_detect(sat_detect),
    .bridge_in1(bridge_in1), .bridge_in2(bridge_in2), .adc_start(adc_start), .adc_valid(adc_valid),
    .adc_code(adc_code), .dc_trip_th(dc_th), .ac_trip_th(ac_th), .hyst_th(hyst_th),
    .relay_trip(relay_trip), .fault_type(fault_type), .monitoring(monitoring));
  fgc_partner u_far (.clk_sys(clk_sys), .rst(rst), .bridge_in1(bridge_in1), .adc_start(adc_start),
    .ac_mode(ac_mode), .level(level), .skew(skew), .sat_detect(sat_detect), .adc_valid(adc_valid),
    .adc_code(adc_code));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  // lowest and highest sample decide the type
  function automatic fgc_fault_t want(input logic [ADC_W-1:0] lv, input logic ac);
    logic [ADC_W-1:0] low;
    low = ac ? '0 : lv;
    if (low > dc_th) return FGC_DC;
    if (low <= NEAR_ZERO_CODE && lv > ac_th) return FGC_AC;
    return FGC_NONE;
  endfunction : want
  task automatic run(input logic [ADC_W-1:0] lv, input logic ac);
    logic m = 1'b0;
    logic arm;
    arm = lv > ((dc_th < ac_th) ? dc_th : ac_th);
    level = lv;
    ac_mode = ac;
    for (int i = 0; i < 3 * WIN && !(m && !monitoring); i++) begin
      m |= monitoring;
      @(negedge clk_sys);
    end
    chk(m === arm, "arming");
    chk(relay_trip === (arm && want(lv, ac) != FGC_NONE), "trip");
    if (relay_trip === 1'b1) chk(fault_type === want(lv, ac), "type");
    level = '0;
    repeat (WIN + 60) @(negedge clk_sys);
    chk(relay_trip === 1'b0 && monitoring === 1'b0, "release");
    $display("test level %0d ac %0d done", lv, ac);
  endtask : run
  task automatic duty(input logic [7:0] sk);
    skew = sk;
    hi = 0;
    lo = 0;
    repeat (3000) begin
      @(negedge clk_sys);
      if (bridge_in1 === 1'b1) hi++; else lo++;
    end
    $display("test duty skew %0d done", sk);
  endtask : duty
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the planned run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    {rst, ac_mode, level, skew} = {1'b1, 1'b0, 10'h000, 8'h00};
    {dc_th, ac_th, hyst_th} = {DC_TRIP_CODE, AC_TRIP_CODE, HYST_CODE};
    void'($urandom(70354));
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk(bridge_in1 === DIR_RST && bridge_in2 === !DIR_RST && relay_trip === 1'b0, "reset");
    duty(8'h00);
    chk(hi - lo <= 30 && lo - hi <= 30, "even duty");
    duty(8'h14);
    chk(hi - lo > 500, "shifted duty");
    run(DC_TRIP_CODE, 1'b0);
    run(DC_TRIP_CODE + 10'h001, 1'b0);
    run(AC_TRIP_CODE, 1'b1);
    run(AC_TRIP_CODE + 10'h001, 1'b1);
    repeat (4) run(10'($urandom_range(700)), 1'($urandom_range(1)));
    dc_th = 10'h12C;
    run(10'h0FA, 1'b0);
    run(10'h1F4, 1'b0);
    tally_and_finish();
  end
endmodule : fgc_top_bench
